//--- core/lta_pair_mode_agc.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "lta_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// (R01) Audio-mode pairs go through gain path
// (R02) Data-mode pairs bypass, bits left unaltered
// (R03) Non-audio payloads pass bit-exact in data mode
// (R04) Auto mode follows packet audio/data bit
// (R05) Independent mode per pair, sixteen channels
// (R06) Report each AES port as input/output
// (R07) One stream per port, compressed may be more
// (R08) Measure 16 channels; single, pair, surround grouping
// (R09) Gradual whole-level gain from level history
// (R10) Switch off ramps gain back to unity
// (R11) Switch on derives correction from measured level
// (R12) Readable present correction in signed dB
// (R13) Silence threshold 0..-70, default -40
// (R14) Target loudness 0..-50, default -24
// (R15) Spread 0..50, default 1, window
// (R16) Transition time 0.5..30 s, default 3
// (R17) Attenuation limit 0..-12 dB, default -12
// (R18) Gain limit 0..+12 dB, default +12
// (R19) Two-minute history for selected channel
// (R20) Output level from average, gain, mixer gain
// (R21) Correction runs independent of history reads
// (R22) Silent channels hold their gain
module lta_pair_mode_agc
#(
	parameter int CHANNELS    = 16,
	parameter int PORTS       = 8,
	parameter int PRE_CYCLES  = `LTA_PRE_CYCLES,
	parameter int HIST_CYCLES = `LTA_HIST_CYCLES,
	parameter int HIST_DEPTH  = `LTA_HIST_DEPTH
)
(
	input  wire logic                     clock,
	input  wire logic                     rstn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [CHANNELS*24-1:0]   inSamples,
	input  wire logic                     inValid,
	input  wire logic [CHANNELS/2-1:0]    pairDataBit,
	input  wire logic [PORTS-1:0]         portIsInput,
	input  wire logic signed [7:0]        mixGainDb,
	output logic [CHANNELS*24-1:0]        outSamples,
	output logic                          outValid
);
	////////////////////////////////////////////////////////////////////////////////
	// Software-visible state
	logic                  master_q;     // Loudness master switch
	logic                  postMix_q;    // Metering after manual mixer gain
	logic [3:0]            histCh_q;     // History channel select
	lta_pkg::lta_link_t    link_q;       // Channel grouping
	logic [15:0]           enable_q;     // Per-channel correction enable
	logic [15:0]           modes_q;      // Two bits per mixer pair
	logic [PORTS-1:0]      portDir_q;    // One when port is an input
	logic [7:0]            silence_q;    // Magnitude of silence level
	logic [7:0]            target_q;     // Magnitude of target level
	logic [7:0]            spread_q;     // Window half-width
	logic [8:0]            ttime_q;      // Transition time, tenths of a second
	logic [3:0]            maxAtt_q;     // Attenuation limit magnitude
	logic [3:0]            maxGain_q;    // Gain limit
	logic [6:0]            histIdx_q;    // History read index, 0 is oldest
	logic [31:0]           prdata_q;
	logic                  pready_q;
	logic                  pslverr_q;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] top);
		return (v > top) ? top : v;
	endfunction

	function automatic logic signed [9:0] sx10(input logic signed [7:0] v);
		return {v[7], v[7], v};
	endfunction

	function automatic logic signed [7:0] max8(input logic signed [7:0] a, input logic signed [7:0] b);
		return (a > b) ? a : b;
	endfunction

	function automatic logic signed [7:0] sat8(input logic signed [9:0] v);
		return (v > 10'sd127) ? 8'sd127 : (v < -10'sd127) ? -8'sd127 : v[7:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB decode: one wait state, answer registered
	logic        access;
	logic        wrEn;
	logic        hitCtrl;
	logic        hitMode;
	logic        hitPort;
	logic        hitLvl;
	logic        hitTt;
	logic        hitLim;
	logic        hitGain;
	logic        hitHIdx;
	logic        hitHDat;
	logic        mapped;
	logic [31:0] readMux;
	logic [8:0]  ttimeIn;

	assign access  = psel && penable && !pready_q;
	assign wrEn    = access && pwrite;
	assign hitCtrl = paddr == `LTA_OFF_CTRL;
	assign hitMode = paddr == `LTA_OFF_MODE;
	assign hitPort = paddr == `LTA_OFF_PORTDIR;
	assign hitLvl  = paddr == `LTA_OFF_LEVELS;
	assign hitTt   = paddr == `LTA_OFF_TTIME;
	assign hitLim  = paddr == `LTA_OFF_LIMITS;
	assign hitGain = paddr == `LTA_OFF_GAIN;
	assign hitHIdx = paddr == `LTA_OFF_HISTIDX;
	assign hitHDat = paddr == `LTA_OFF_HISTDATA;
	assign mapped  = hitCtrl | hitMode | hitPort | hitLvl | hitTt | hitLim | hitGain | hitHIdx | hitHDat;
	// Out-of-range transition time clamps into 0.5..30 s
	assign ttimeIn = (pwdata[8:0] < `LTA_MIN_TTIME) ? `LTA_MIN_TTIME :
	                 (pwdata[8:0] > `LTA_MAX_TTIME) ? `LTA_MAX_TTIME : pwdata[8:0]; // R16

	////////////////////////////////////////////////////////////////////////////////
	// Time base: dB step prescaler, transition-time step counter, history tick
	logic [23:0] preCnt_q;
	logic [8:0]  stepCnt_q;
	logic [24:0] histCnt_q;
	logic        preTick;
	logic        stepTick;
	logic        histTick;

	assign preTick  = preCnt_q == 24'(PRE_CYCLES - 1);
	// Full 12 dB swing takes the transition time, four clocks short per tenth of a second
	assign stepTick = preTick && (stepCnt_q >= ttime_q - 9'h001); // R16
	assign histTick = histCnt_q == 25'(HIST_CYCLES - 1);

	// Free-running counters
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			preCnt_q  <= 24'h000000;
			stepCnt_q <= 9'h000;
			histCnt_q <= 25'h0000000;
		end
		else
		begin
			preCnt_q  <= preTick ? 24'h000000 : preCnt_q + 24'h000001;
			stepCnt_q <= stepTick ? 9'h000 : (preTick ? stepCnt_q + 9'h001 : stepCnt_q);
			histCnt_q <= histTick ? 25'h0000000 : histCnt_q + 25'h0000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Level measurement, one meter per channel
	logic signed [7:0]  levelDb [CHANNELS];
	logic signed [7:0]  avgDb   [CHANNELS];
	logic signed [7:0]  grpDb   [CHANNELS];
	logic signed [5:0]  gain_q  [CHANNELS];
	logic signed [5:0]  gain_d  [CHANNELS];
	logic signed [23:0] gained  [CHANNELS];
	logic               dataPair[CHANNELS/2];

	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_chan
		// Independent measurement on every channel
		lta_level_meter u_meter
		(
			.clock       (clock),
			.rstn        (rstn),
			.sampleValid (inValid),
			.sample      (inSamples[c*24 +: 24]),
			.tick        (preTick),
			.level       (levelDb[c]),
			.average     (avgDb[c])
		); // R08
		// Whole-level scaling, no compression
		lta_gain_apply u_gain
		(
			.sample (inSamples[c*24 +: 24]),
			.gainDb (gain_q[c]),
			.result (gained[c])
		); // R09
	end

	// Pair handling: data or auto-with-data-bit bypasses the loudness gain path
	for (genvar p = 0; p < CHANNELS/2; p++)
	begin : g_pair
		assign dataPair[p] = (modes_q[2*p +: 2] == lta_pkg::LTA_DATA) ||
		                     ((modes_q[2*p +: 2] == lta_pkg::LTA_AUTO) && pairDataBit[p]); // R02 R04 R05
	end

	// Grouped level: loudest member of the group drives the correction
	always_comb
	begin
		logic signed [7:0] surr;
		surr = -8'sd127;
		for (int c = 0; c < CHANNELS; c++)
			if (enable_q[c])
				surr = max8(surr, avgDb[c]);
		for (int c = 0; c < CHANNELS; c++)
		begin
			unique case (link_q)
				lta_pkg::LTA_PAIR:     grpDb[c] = max8(avgDb[c], avgDb[c ^ 1]); // R08
				lta_pkg::LTA_SURROUND: grpDb[c] = surr; // R08
				default:               grpDb[c] = avgDb[c];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gain controller: one dB per step tick, limits enforced at once while the master switch is on
	always_comb
	begin
		logic signed [9:0] corr;
		logic signed [9:0] lo;
		logic signed [9:0] hi;
		logic signed [5:0] gMax;
		logic signed [5:0] gMin;
		corr = 10'sd0;
		lo   = -sx10(8'(target_q + spread_q)); // R14 R15
		hi   = sx10(8'(spread_q - target_q)); // R15
		gMax = {2'h0, maxGain_q};
		gMin = -{2'h0, maxAtt_q};
		for (int c = 0; c < CHANNELS; c++)
		begin
			gain_d[c] = gain_q[c];
			corr      = sx10(grpDb[c]) + {{4{gain_q[c][5]}}, gain_q[c]};
			if (stepTick)
			begin
				if (!master_q || !enable_q[c])
				begin
					// Ease back toward unity rather than jumping
					if (gain_q[c] > 6'sd0)
						gain_d[c] = gain_q[c] - 6'sd1; // R10
					else if (gain_q[c] < 6'sd0)
						gain_d[c] = gain_q[c] + 6'sd1; // R10
				end
				else if (grpDb[c] <= -$signed({1'b0, silence_q[6:0]}))
					gain_d[c] = gain_q[c]; // R13 R22
				else if (corr < lo && gain_q[c] < gMax)
					gain_d[c] = gain_q[c] + 6'sd1; // R11 R18
				else if (corr > hi && gain_q[c] > gMin)
					gain_d[c] = gain_q[c] - 6'sd1; // R11 R17
			end
			// Lowered limits take effect immediately while the master switch is on
			if (master_q && gain_d[c] > gMax)
				gain_d[c] = gMax; // R18
			if (master_q && gain_d[c] < gMin)
				gain_d[c] = gMin; // R17
		end
	end

	// Gain state, unaffected by any history access
	always_ff @(posedge clock)
	begin
		for (int c = 0; c < CHANNELS; c++)
			gain_q[c] <= !rstn ? 6'sd0 : gain_d[c]; // R21
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample path: registered, bypass is a straight copy
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			outSamples <= '0;
			outValid   <= 1'b0;
		end
		else
		begin
			outValid <= inValid;
			for (int c = 0; c < CHANNELS; c++)
				if (inValid)
					outSamples[c*24 +: 24] <= dataPair[c/2] ? inSamples[c*24 +: 24] : gained[c]; // R01 R02 R03 R07
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// History of the selected channel: one entry per second, 120 deep
	logic [31:0]       histMem [HIST_DEPTH];
	logic [6:0]        wrPtr_q;
	logic [6:0]        rdAddr;
	logic [7:0]        rdSum;
	logic signed [7:0] finalDb;
	logic signed [7:0] selGain;

	assign selGain = {{2{gain_q[histCh_q][5]}}, gain_q[histCh_q]};
	// Output level includes manual gain only when metered after the mixer
	assign finalDb = sat8(sx10(avgDb[histCh_q]) + sx10(selGain) + (postMix_q ? sx10(mixGainDb) : 10'sd0)); // R20
	assign rdSum   = {1'b0, wrPtr_q} + {1'b0, histIdx_q};
	assign rdAddr  = (rdSum >= 8'(HIST_DEPTH)) ? 7'(rdSum - 8'(HIST_DEPTH)) : rdSum[6:0];

	// Ring write: oldest entry is overwritten each second
	always_ff @(posedge clock)
	begin
		if (!rstn)
			wrPtr_q <= 7'h00;
		else if (histTick)
		begin
			histMem[wrPtr_q] <= {levelDb[histCh_q], avgDb[histCh_q], selGain, finalDb}; // R19
			wrPtr_q          <= (wrPtr_q == 7'(HIST_DEPTH - 1)) ? 7'h00 : wrPtr_q + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read selection
	assign readMux = hitCtrl ? {enable_q, 6'h00, link_q, histCh_q, 2'h0, postMix_q, master_q} :
	                 hitMode ? {16'h0000, modes_q} :
	                 hitPort ? 32'(portDir_q) : // R06
	                 hitLvl  ? {8'h00, spread_q, target_q, silence_q} :
	                 hitTt   ? {23'h000000, ttime_q} :
	                 hitLim  ? {20'h00000, maxGain_q, 4'h0, maxAtt_q} :
	                 hitGain ? {{24{selGain[7]}}, selGain} : // R12
	                 hitHIdx ? {9'h000, wrPtr_q, 9'h000, histIdx_q} :
	                 hitHDat ? histMem[rdAddr] : 32'h00000000; // R19

	// Bus answer: ready one cycle into the access phase; unmapped gives an error
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= access;
			pslverr_q <= access && !mapped;
			prdata_q  <= (access && !pwrite) ? readMux : 32'h00000000;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Port direction report follows the port controls
	always_ff @(posedge clock)
	begin
		portDir_q <= !rstn ? '0 : portIsInput; // R06
	end

	// Control and configuration writes, level, time, limit and history-index values clamped to legal ranges
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			master_q  <= 1'b0;
			postMix_q <= 1'b0;
			histCh_q  <= 4'h0;
			link_q    <= lta_pkg::LTA_SINGLE;
			enable_q  <= 16'hffff;
			modes_q   <= 16'h0000;
			silence_q <= `LTA_RST_SILENCE; // R13
			target_q  <= `LTA_RST_TARGET; // R14
			spread_q  <= `LTA_RST_SPREAD; // R15
			ttime_q   <= `LTA_RST_TTIME; // R16
			maxAtt_q  <= `LTA_RST_MAXATT; // R17
			maxGain_q <= `LTA_RST_MAXGAIN; // R18
			histIdx_q <= 7'h00;
		end
		else if (wrEn)
		begin
			if (hitCtrl)
			begin
				master_q  <= pwdata[`LTA_CTRL_MASTER];
				postMix_q <= pwdata[`LTA_CTRL_POSTMIX];
				histCh_q  <= pwdata[`LTA_CTRL_CH_LSB +: 4];
				link_q    <= lta_pkg::lta_link_t'(pwdata[`LTA_CTRL_LINK_LSB +: 2]);
				enable_q  <= pwdata[`LTA_CTRL_EN_LSB +: 16];
			end
			if (hitMode)
				modes_q <= pwdata[15:0]; // R05
			if (hitLvl)
			begin
				silence_q <= clamp8(pwdata[7:0], `LTA_MAX_SILENCE); // R13
				target_q  <= clamp8(pwdata[15:8], `LTA_MAX_TARGET); // R14
				spread_q  <= clamp8(pwdata[23:16], `LTA_MAX_SPREAD); // R15
			end
			if (hitTt)
				ttime_q <= ttimeIn;
			if (hitLim)
			begin
				maxAtt_q  <= (pwdata[3:0] > `LTA_MAX_LIMIT) ? `LTA_MAX_LIMIT : pwdata[3:0]; // R17
				maxGain_q <= (pwdata[11:8] > `LTA_MAX_LIMIT) ? `LTA_MAX_LIMIT : pwdata[11:8]; // R18
			end
			if (hitHIdx)
				histIdx_q <= (pwdata[6:0] >= 7'(HIST_DEPTH)) ? 7'(HIST_DEPTH - 1) : pwdata[6:0];
		end
	end
endmodule

//--- core/lta_defines.svh
`ifndef LTA_DEFINES_SVH
`define LTA_DEFINES_SVH

// Register byte offsets
`define LTA_OFF_CTRL      8'h00
`define LTA_OFF_MODE      8'h04
`define LTA_OFF_PORTDIR   8'h08
`define LTA_OFF_LEVELS    8'h0c
`define LTA_OFF_TTIME     8'h10
`define LTA_OFF_LIMITS    8'h14
`define LTA_OFF_GAIN      8'h18
`define LTA_OFF_HISTIDX   8'h1c
`define LTA_OFF_HISTDATA  8'h20

// Control register fields
`define LTA_CTRL_MASTER   0
`define LTA_CTRL_POSTMIX  1
`define LTA_CTRL_CH_LSB   4
`define LTA_CTRL_LINK_LSB 8
`define LTA_CTRL_EN_LSB   16

// Reset values, floor and ceilings (magnitudes: silence, target, attenuation are negative dB)
`define LTA_RST_SILENCE   8'h28
`define LTA_MAX_SILENCE   8'h46
`define LTA_RST_TARGET    8'h18
`define LTA_MAX_TARGET    8'h32
`define LTA_RST_SPREAD    8'h01
`define LTA_MAX_SPREAD    8'h32
`define LTA_RST_TTIME     9'h01e
`define LTA_MIN_TTIME     9'h005
`define LTA_MAX_TTIME     9'h12c
`define LTA_RST_MAXATT    4'hc
`define LTA_RST_MAXGAIN   4'hc
`define LTA_MAX_LIMIT     4'hc

// Timing: clock period, transition time unit (0.1 s), history sample period (1 s)
`define LTA_CLK_NS        40
`define LTA_TENTH_NS      100000000
`define LTA_HIST_NS       1000000000
`define LTA_SPAN_DB       12
`define LTA_PRE_CYCLES    (`LTA_TENTH_NS / `LTA_CLK_NS / `LTA_SPAN_DB)
`define LTA_HIST_CYCLES   (`LTA_HIST_NS / `LTA_CLK_NS)
`define LTA_HIST_DEPTH    120

`endif

//--- core/lta_pkg.sv
package lta_pkg;
	// Per-pair handling of mixer inputs
	typedef enum logic [1:0] {LTA_AUDIO, LTA_DATA, LTA_AUTO} lta_mode_t;
	// How channels are grouped for loudness measurement
	typedef enum logic [1:0] {LTA_SINGLE, LTA_PAIR, LTA_SURROUND} lta_link_t;
endpackage

//--- core/lta_level_meter.sv
`timescale 1ns/1ps
// Peak level per window in whole dB below full scale, plus a slow average
module lta_level_meter
(
	input  wire logic               clock,
	input  wire logic               rstn,
	input  wire logic               sampleValid,
	input  wire logic signed [23:0] sample,
	input  wire logic               tick,
	output logic signed [7:0]       level,
	output logic signed [7:0]       average
);
	logic [23:0]        peak_q;   // Largest magnitude this window
	logic signed [7:0]  level_q;  // Last window level
	logic signed [11:0] avg_q;    // Average, four fraction bits
	logic [23:0]        mag;
	logic signed [7:0]  winDb;
	logic signed [11:0] avgDelta;

	// About 6 dB per bit; silence floors at -127
	function automatic logic signed [7:0] to_db(input logic [23:0] m);
		int db;
		db = -127;
		for (int b = 0; b < 24; b++)
			if (m[b])
				db = -6 * (23 - b);
		if (db < -127)
			db = -127;
		return 8'(db);
	endfunction

	assign mag      = sample[23] ? 24'(-sample) : sample;
	assign winDb    = to_db(peak_q);
	// Window level scaled to four fraction bits before the difference is taken
	assign avgDelta = $signed({winDb, 4'h0}) - avg_q;
	assign level    = level_q;
	assign average  = avg_q[11:4];

	// Peak hold, restarted from the current sample's magnitude at each window tick
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			peak_q  <= 24'h000000;
			level_q <= -8'sd127;
			avg_q   <= -12'sd2032;
		end
		else if (tick)
		begin
			peak_q  <= (sampleValid && mag > 24'h000000) ? mag : 24'h000000;
			level_q <= winDb;
			avg_q   <= avg_q + (avgDelta >>> 3);
		end
		else if (sampleValid && mag > peak_q)
			peak_q <= mag;
	end
endmodule

//--- core/lta_gain_apply.sv
`timescale 1ns/1ps
// Scales a sample by a whole-dB gain, -12..+12, with saturation
module lta_gain_apply
(
	input  wire logic signed [23:0] sample,
	input  wire logic signed [5:0]  gainDb,
	output logic signed [23:0]      result
);
	logic [4:0]         g;       // Gain offset to 6..30
	logic [2:0]         k;       // Whole 6 dB steps
	logic [2:0]         r;       // Remaining dB
	logic signed [16:0] coef;    // Q2.14 fraction for r dB
	logic signed [40:0] prod;
	logic signed [40:0] shifted;

	function automatic logic signed [16:0] frac_coef(input logic [2:0] d);
		unique case (d)
			3'h0: return 17'sh04000;
			3'h1: return 17'sh047cf;
			3'h2: return 17'sh05092;
			3'h3: return 17'sh05a67;
			3'h4: return 17'sh0656f;
			default: return 17'sh071cf;
		endcase
	endfunction

	assign g       = 5'(gainDb + 6'sd18);
	assign k       = 3'(g / 5'h06);
	assign r       = 3'(g % 5'h06);
	assign coef    = frac_coef(r);
	assign prod    = 41'(sample) * 41'(coef);
	assign shifted = prod >>> (5'h11 - {2'h0, k});
	// Clip instead of wrapping on gain overflow
	assign result  = (shifted > 41'sh00007fffff) ? 24'sh7fffff :
	                 (shifted < -41'sh0000800000) ? -24'sh800000 : shifted[23:0];
endmodule

//--- verif/lta_agc_chk.sv
`timescale 1ns/1ps
// Port watcher: APB timing and sample-path timing of the block
module lta_agc_chk
#(
	parameter int CHANNELS = 16
)
(
	input wire logic                  clock,
	input wire logic                  rstn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  inValid,
	input wire logic [CHANNELS*24-1:0] outSamples,
	input wire logic                  outValid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////////////
	// One wait state, then a single answer cycle
	ready_after_access_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	ready_needs_access_a: assert property (pready |-> $past(psel && penable))
		else $error("answer without access");
	// Read data is only driven while answering
	rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	// Addresses past the map or misaligned are refused
	err_unmapped_a: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	err_mapped_a: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	// Each frame taken comes out one cycle later, held between frames
	frame_follows_a: assert property (inValid |=> outValid)
		else $error("frame not passed on");
	frame_alone_a: assert property (!inValid |=> !outValid)
		else $error("output frame without input");
	samples_hold_a: assert property (!inValid |=> $stable(outSamples))
		else $error("outputs moved between frames");
endmodule

bind lta_pair_mode_agc lta_agc_chk #(.CHANNELS(CHANNELS)) chk (.clock(clock), .rstn(rstn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.inValid(inValid), .outSamples(outSamples), .outValid(outValid));

//--- verif/pair_mode_and_loudness_agc_test.sv
`timescale 1ns/1ps
module pair_mode_and_loudness_agc_test;
	logic               clock        = 1'b0;
	logic               rstn         = 1'b0;
	logic               psel         = 1'b0;
	logic               penable      = 1'b0;
	logic               pwrite       = 1'b0;
	logic [7:0]         paddr        = 8'h00;
	logic [31:0]        pwdata       = 32'h0;
	logic [383:0]       inSamples    = '0;
	logic               inValid      = 1'b0;
	logic               streamOn     = 1'b0;
	logic [7:0]         pairDataBit  = 8'h04;
	logic [7:0]         portIsInput  = 8'h30;
	logic signed [7:0]  mixGainDb    = 8'sh00;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [383:0]       outSamples;
	logic               outValid;
	logic [31:0]        rd;
	logic               er;
	int                 n_mismatch   = 0;
	int                 total_checks = 0;
	int                 cycles       = 0;

	// Short step and history periods keep the run small
	lta_pair_mode_agc #(.PRE_CYCLES(4), .HIST_CYCLES(50)) uut (.clock(clock), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .inSamples(inSamples), .inValid(inValid), .pairDataBit(pairDataBit),
		.portIsInput(portIsInput), .mixGainDb(mixGainDb), .outSamples(outSamples), .outValid(outValid));

	////////////////////////////////////////////////////////////////////////////////
	always #20 clock = ~clock;
	// Frames every other cycle while the stream runs
	always @(posedge clock)
	begin
		inValid <= streamOn & ~inValid;
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for the answer, a hung slave is caught by the cycle ceiling
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdChk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	task setSamples(input logic [23:0] quiet);
		for (int c = 0; c < 16; c++)
			inSamples[c*24+:24] <= (c >= 2 && c < 6) ? 24'h96a5c3 : quiet;
		streamOn <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task testResetValues;
		logic [7:0]  adr [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h08};
		logic [31:0] exv [7] = '{32'hffff0000, 32'h0, 32'h00011828, 32'h1e, 32'hc0c, 32'h0, 32'h30};
		for (int i = 0; i < 7; i++)
			rdChk(adr[i], exv[i]);
	endtask

	// Out-of-range settings clamp; unmapped place refused
	task testClampAndRefuse;
		apb(1'b1, 8'h0c, 32'hffffffff);
		rdChk(8'h0c, 32'h00323246);
		apb(1'b1, 8'h10, 32'h0);
		rdChk(8'h10, 32'h5);
		apb(1'b1, 8'h10, 32'h3e8);
		rdChk(8'h10, 32'h12c);
		apb(1'b1, 8'h14, 32'h0f0f);
		rdChk(8'h14, 32'hc0c);
		apb(1'b1, 8'h40, 32'h1);
		check({31'h0, er}, 32'h1);
		rdChk(8'h40, 32'h0);
		check({31'h0, er}, 32'h1);
	endtask

	// Silent input holds gain, lower silence threshold lets it rise to the limit
	task testGainAndModes;
		apb(1'b1, 8'h04, 32'ha4);
		rdChk(8'h04, 32'ha4);
		setSamples(24'h010000);
		apb(1'b1, 8'h0c, 32'h00011828);
		apb(1'b1, 8'h10, 32'h5);
		apb(1'b1, 8'h00, 32'hffff0001);
		repeat (200) @(posedge clock);
		rdChk(8'h18, 32'h0);
		apb(1'b1, 8'h0c, 32'h00011846);
		repeat (600) @(posedge clock);
		rdChk(8'h18, 32'hc);
		check({31'h0, outSamples[23:0] > 24'h010000}, 32'h1);
		for (int c = 2; c < 6; c++)
			check({8'h0, outSamples[c*24+:24]}, 32'h0096a5c3);
		check({31'h0, outSamples[6*24+:24] > 24'h010000}, 32'h1);
	endtask

	task testLimitsAndOff;
		logic [6:0] ptr;
		apb(1'b1, 8'h14, 32'h0000030c);
		repeat (4) @(posedge clock);
		rdChk(8'h18, 32'h3);
		apb(1'b1, 8'h14, 32'h00000c05);
		setSamples(24'h7fffff);
		repeat (500) @(posedge clock);
		rdChk(8'h18, 32'hfffffffb);
		apb(1'b0, 8'h1c, 32'h0);
		ptr = rd[22:16];
		apb(1'b1, 8'h00, 32'hffff0000);
		apb(1'b0, 8'h18, 32'h0);
		check({31'h0, rd !== 32'h0}, 32'h1);
		setSamples(24'h010000);
		repeat (300) @(posedge clock);
		rdChk(8'h18, 32'h0);
		check({8'h0, outSamples[23:0]}, 32'h00010000);
		apb(1'b0, 8'h1c, 32'h0);
		check({31'h0, rd[22:16] != ptr}, 32'h1);
	endtask

	// Newest history entry with and without mixer gain, surround grouping, port report
	task testHistoryAndGroups;
		apb(1'b1, 8'h1c, 32'h77);
		rdChk(8'h20, 32'hd6d600d6);
		mixGainDb <= 8'sh03;
		apb(1'b1, 8'h00, 32'hffff0002);
		repeat (60) @(posedge clock);
		rdChk(8'h20, 32'hd6d600d9);
		apb(1'b1, 8'h00, 32'hffff0201);
		repeat (200) @(posedge clock);
		rdChk(8'h18, 32'hfffffffb);
		portIsInput <= 8'hc3;
		rdChk(8'h08, 32'hc3);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		testResetValues();
		testClampAndRefuse();
		testGainAndModes();
		testLimitsAndOff();
		testHistoryAndGroups();
		stop_test();
	end
endmodule
